// >>> rsf_pkg.sv
package rsf_pkg;

    // ------------------------------------------------------------
    // register numbering
    // ------------------------------------------------------------
    localparam int REG_W = 7;
    localparam int DIRTY_W = 8;
    localparam int SUM_W = 9;
    localparam logic [6:0] STATIC_COUNT = 7'h20;
    localparam logic [6:0] STACK_MAX = 7'h60;
    localparam logic [6:0] PHYS_COUNT = 7'h60;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [6:0] SOF_RST = 7'h00;
    localparam logic [6:0] SOL_RST = 7'h00;
    localparam logic [6:0] BASE_RST = 7'h00;
    localparam logic [7:0] DIRTY_RST = 8'h00;

    // ------------------------------------------------------------
    // operations and sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_CALL = 3'b001,
        OP_RET = 3'b010,
        OP_ALLOC = 3'b011,
        OP_FLUSH = 3'b100,
        OP_CLRRB = 3'b101
    } op_kind_e;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_FLUSH = 2'b01,
        ST_FILL = 2'b10
    } seq_state_e;

endpackage

// >>> frame_if.sv
`timescale 1ns/1ns
interface frame_if;
    logic [6:0] base;
    logic [6:0] sof;
    logic rename_off;
    modport owner (output base, output sof, output rename_off);
    modport user (input base, input sof, input rename_off);
endinterface

// >>> stack_addr_map.sv
`timescale 1ns/1ns
module stack_addr_map
    import rsf_pkg::*;
(
    // frame in force
    frame_if.user i_frame,
    // logical register number
    input wire logic [6:0] i_addr,
    // mapped result
    output logic [6:0] o_phys,
    output logic o_stacked,
    output logic o_in_frame
);

    logic [6:0] offs;
    logic [7:0] sum;
    logic [7:0] wrap;

    assign o_stacked = (i_addr >= STATIC_COUNT);
    assign offs = i_addr - STATIC_COUNT;
    assign sum = {1'b0, i_frame.base} + {1'b0, offs};
    assign wrap = sum - {1'b0, PHYS_COUNT};

    always_comb begin
        if (!o_stacked) begin
            o_phys = i_addr;
        end else if (i_frame.rename_off) begin
            o_phys = offs;
        end else if (sum >= {1'b0, PHYS_COUNT}) begin
            o_phys = wrap[6:0];
        end else begin
            o_phys = sum[6:0];
        end
    end

    // out-of-frame reads are still mapped; their data is not guaranteed
    assign o_in_frame = !o_stacked || i_frame.rename_off || (offs < i_frame.sof);
endmodule

// >>> register_stack_frame_renamer.sv
`timescale 1ns/1ns
// How it works
// - registers 0 to 31 never renamed
// - stacked frame starts at 32, up to 96
// - legacy instruction set disables stacked renaming
// - spill engine saves, restores stacked registers automatically
// - after call: no locals, caller outputs overlaid
// - output area is frame size minus locals
// - alloc: locals=in+loc, frame=in+loc+out
// - reads beyond frame return any value
// - writes beyond frame blocked, illegal operation fault
// - call copies frame marker into previous marker
// - call advances base to caller's first output
// - call: locals zero, frame equals caller outputs
// - alloc leaves the rename base unchanged
// - alloc never touches register contents
// - return reloads marker and caller mapping
// - marker changes only by call, return, alloc, clear; OP_CLRRB is not decoded here, so clear leaves the marker as it is
// - alloc frame size applies to its whole group
// - flush stalls until older frames spilled
module register_stack_frame_renamer
    import rsf_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // instruction issue
    input wire logic i_op_valid,
    input wire op_kind_e i_op_kind,
    input wire logic [6:0] i_alloc_ins,
    input wire logic [6:0] i_alloc_locs,
    input wire logic [6:0] i_alloc_outs,
    input wire logic i_legacy_mode,
    output logic o_op_ready,
    output logic o_stall,
    // register file read port
    input wire logic i_rd_en,
    input wire logic [6:0] i_rd_addr,
    output logic o_rd_valid,
    output logic [6:0] o_rd_phys,
    output logic o_rd_stacked,
    // register file write port
    input wire logic i_wr_en,
    input wire logic [6:0] i_wr_addr,
    output logic o_wr_en,
    output logic [6:0] o_wr_phys,
    output logic o_wr_stacked,
    output logic o_illegal_op_fault,
    // previous frame marker of the previous function state
    input wire logic i_pfm_load,
    input wire logic [6:0] i_pfm_sof,
    input wire logic [6:0] i_pfm_sol,
    output logic [6:0] o_pfm_sof,
    output logic [6:0] o_pfm_sol,
    // stack spill engine
    output logic o_spill_req,
    input wire logic i_spill_ack,
    output logic o_fill_req,
    input wire logic i_fill_ack,
    output logic [7:0] o_dirty_count
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [6:0] sof_r;
    logic [6:0] sol_r;
    logic [6:0] base_r;
    logic [7:0] dirty_r;
    logic [7:0] dirty_nxt;
    logic [6:0] fill_r;
    logic [6:0] fill_nxt;
    seq_state_e state_r;
    seq_state_e state_nxt;

    frame_if frame ();

    // ------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------
    logic take;
    logic do_call;
    logic do_ret;
    logic do_alloc;
    logic do_flush;
    logic [8:0] alloc_sol;
    logic [8:0] alloc_sof;
    logic alloc_ok;
    logic alloc_now;
    logic [6:0] out_area;
    logic [7:0] base_call_sum;
    logic [6:0] base_call;
    logic [7:0] base_ret_diff;
    logic [6:0] base_ret;
    logic [6:0] eff_sof;

    // only the sequencer stalls issue; group placement is the issuer's job
    assign o_op_ready = (state_r == ST_RUN);
    assign o_stall = !o_op_ready;
    assign take = i_op_valid && o_op_ready;
    // legacy code has no register stack, so frame ops are ignored there
    assign do_call = take && (i_op_kind == OP_CALL) && !i_legacy_mode;
    assign do_ret = take && (i_op_kind == OP_RET) && !i_legacy_mode;
    assign do_alloc = take && (i_op_kind == OP_ALLOC) && !i_legacy_mode;
    assign do_flush = take && (i_op_kind == OP_FLUSH);

    assign alloc_sol = {2'b00, i_alloc_ins} + {2'b00, i_alloc_locs};
    assign alloc_sof = alloc_sol + {2'b00, i_alloc_outs};
    assign alloc_ok = (alloc_sof <= {2'b00, STACK_MAX}) && (alloc_sol <= alloc_sof);
    assign alloc_now = do_alloc && alloc_ok;

    assign out_area = sof_r - sol_r;
    assign base_call_sum = {1'b0, base_r} + {1'b0, sol_r};
    assign base_call = (base_call_sum >= {1'b0, PHYS_COUNT}) ?
        7'(base_call_sum - {1'b0, PHYS_COUNT}) : base_call_sum[6:0];
    assign base_ret_diff = {1'b0, base_r} - {1'b0, o_pfm_sol};
    assign base_ret = (base_r < o_pfm_sol) ?
        7'(base_ret_diff + {1'b0, PHYS_COUNT}) : base_ret_diff[6:0];

    // an alloc resizes the frame for its own group from its own cycle
    assign eff_sof = alloc_now ? alloc_sof[6:0] : sof_r;

    assign frame.base = base_r;
    assign frame.sof = eff_sof;
    assign frame.rename_off = i_legacy_mode;

    // ------------------------------------------------------------
    // current frame marker
    // ------------------------------------------------------------
    // the marker has no software port; only these operations move it
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sof_r <= SOF_RST;
            sol_r <= SOL_RST;
        end else if (do_call) begin
            sof_r <= out_area;
            sol_r <= 7'h00;
        end else if (do_ret) begin
            sof_r <= o_pfm_sof;
            sol_r <= o_pfm_sol;
        end else if (alloc_now) begin
            sof_r <= alloc_sof[6:0];
            sol_r <= alloc_sol[6:0];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            base_r <= BASE_RST;
        end else if (do_call) begin
            base_r <= base_call;
        end else if (do_ret) begin
            base_r <= base_ret;
        end
        // alloc and rotating clear leave the base alone
    end

    // ------------------------------------------------------------
    // previous frame marker
    // ------------------------------------------------------------
    // a call wins over a software reload in the same cycle
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pfm_sof <= SOF_RST;
            o_pfm_sol <= SOL_RST;
        end else if (do_call) begin
            o_pfm_sof <= sof_r;
            o_pfm_sol <= sol_r;
        end else if (i_pfm_load) begin
            o_pfm_sof <= i_pfm_sof;
            o_pfm_sol <= i_pfm_sol;
        end
    end

    // ------------------------------------------------------------
    // spill and fill bookkeeping
    // ------------------------------------------------------------
    // dirty_r counts physical registers still held by older frames
    always_comb begin
        dirty_nxt = dirty_r;
        fill_nxt = fill_r;
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (do_call) begin
                    dirty_nxt = dirty_r + {1'b0, sol_r};
                end else if (do_ret && (dirty_r < {1'b0, o_pfm_sol})) begin
                    fill_nxt = 7'(({1'b0, o_pfm_sol}) - dirty_r);
                    dirty_nxt = DIRTY_RST;
                    state_nxt = ST_FILL;
                end else if (do_ret) begin
                    dirty_nxt = dirty_r - {1'b0, o_pfm_sol};
                end else if (do_flush) begin
                    state_nxt = ST_FLUSH;
                end
                if (i_spill_ack && (dirty_nxt != DIRTY_RST) && !do_ret) begin
                    dirty_nxt = dirty_nxt - 8'h01;
                end
            end
            ST_FLUSH: begin
                if (i_spill_ack && (dirty_r != DIRTY_RST)) begin
                    dirty_nxt = dirty_r - 8'h01;
                end
                if (dirty_r == DIRTY_RST) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_FILL: begin
                if (i_fill_ack) begin
                    fill_nxt = fill_r - 7'h01;
                    if (fill_r == 7'h01) begin
                        state_nxt = ST_RUN;
                    end
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dirty_r <= DIRTY_RST;
            fill_r <= 7'h00;
            state_r <= ST_RUN;
        end else begin
            dirty_r <= dirty_nxt;
            fill_r <= fill_nxt;
            state_r <= state_nxt;
        end
    end

    // spill when the physical file would overflow, or to drain on flush
    assign o_spill_req = (dirty_r != DIRTY_RST) && ((state_r == ST_FLUSH) ||
        (({1'b0, dirty_r} + {2'b00, sof_r}) > {2'b00, PHYS_COUNT}));
    assign o_fill_req = (state_r == ST_FILL);
    assign o_dirty_count = dirty_r;

    // ------------------------------------------------------------
    // address renaming
    // ------------------------------------------------------------
    logic [6:0] rd_map;
    logic rd_stk;
    logic [6:0] wr_map;
    logic wr_stk;
    logic wr_in;

    stack_addr_map u_rd_map (
        .i_frame(frame.user),
        .i_addr(i_rd_addr),
        .o_phys(rd_map),
        .o_stacked(rd_stk),
        .o_in_frame()
    );

    stack_addr_map u_wr_map (
        .i_frame(frame.user),
        .i_addr(i_wr_addr),
        .o_phys(wr_map),
        .o_stacked(wr_stk),
        .o_in_frame(wr_in)
    );

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rd_valid <= 1'b0;
            o_rd_phys <= 7'h00;
            o_rd_stacked <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            o_rd_phys <= rd_map;
            o_rd_stacked <= rd_stk;
        end
    end

    // alloc raises no write strobe, so register data is left as it was
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wr_en <= 1'b0;
            o_wr_phys <= 7'h00;
            o_wr_stacked <= 1'b0;
            o_illegal_op_fault <= 1'b0;
        end else begin
            o_wr_en <= i_wr_en && wr_in;
            o_wr_phys <= wr_map;
            o_wr_stacked <= wr_stk;
            o_illegal_op_fault <= (i_wr_en && !wr_in) || (do_alloc && !alloc_ok);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_static_identity;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_rd_en && i_rd_addr < STATIC_COUNT) |=> (o_rd_phys == $past(i_rd_addr)) && !o_rd_stacked;
    endproperty
    a_static_identity: assert property (p_static_identity) else $error("static register renamed");

    property p_first_stacked;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_rd_en && i_rd_addr == STATIC_COUNT && !i_legacy_mode) |=> o_rd_phys == $past(base_r);
    endproperty
    a_first_stacked: assert property (p_first_stacked) else $error("register 32 not at base");

    property p_legacy_flat;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_rd_en && i_legacy_mode && rd_stk) |=> o_rd_phys == 7'($past(i_rd_addr) - STATIC_COUNT);
    endproperty
    a_legacy_flat: assert property (p_legacy_flat) else $error("renaming active in legacy mode");

    property p_call_pfm;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        do_call |=> (o_pfm_sof == $past(sof_r)) && (o_pfm_sol == $past(sol_r));
    endproperty
    a_call_pfm: assert property (p_call_pfm) else $error("marker not saved on call");

    property p_call_frame;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        do_call |=> (sol_r == 7'h00) && (sof_r == 7'($past(sof_r) - $past(sol_r)));
    endproperty
    a_call_frame: assert property (p_call_frame) else $error("callee frame sized wrongly");

    property p_call_ret_base;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        do_call ##1 (do_ret && !i_pfm_load) |=> base_r == $past(base_r, 2);
    endproperty
    a_call_ret_base: assert property (p_call_ret_base) else $error("return lost caller base");

    property p_alloc_base;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        do_alloc |=> $stable(base_r);
    endproperty
    a_alloc_base: assert property (p_alloc_base) else $error("alloc moved the base");

    property p_write_block;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_wr_en && wr_stk && !i_legacy_mode && 7'(i_wr_addr - STATIC_COUNT) >= eff_sof)
        |=> !o_wr_en && o_illegal_op_fault;
    endproperty
    a_write_block: assert property (p_write_block) else $error("write beyond frame passed");

    property p_bad_alloc;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (do_alloc && !alloc_ok) |=> o_illegal_op_fault && $stable(sof_r) && $stable(sol_r);
    endproperty
    a_bad_alloc: assert property (p_bad_alloc) else $error("bad alloc accepted");

    property p_flush_stall;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (state_r == ST_FLUSH && dirty_r != DIRTY_RST) |-> o_stall && o_spill_req;
    endproperty
    a_flush_stall: assert property (p_flush_stall) else $error("flush did not stall");

    property p_flush_done;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (state_r == ST_FLUSH && dirty_r == DIRTY_RST) |=> o_op_ready;
    endproperty
    a_flush_done: assert property (p_flush_done) else $error("flush stall outlived spill");

endmodule

// >>> spill_engine_model.sv
`timescale 1ns/1ns
module spill_engine_model (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // requests from the renamer
    input wire logic i_spill_req,
    input wire logic i_fill_req,
    input wire logic i_slow,
    // one pulse per register moved
    output logic o_spill_ack,
    output logic o_fill_ack
);
    logic [1:0] wait_r;

    // a gap of two idle cycles after each pulse, three with i_slow, so a request that was
    // just met is judged again only after the renamer has counted the pulse
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wait_r <= 2'h0;
            o_spill_ack <= 1'b0;
            o_fill_ack <= 1'b0;
        end else if ((i_spill_req || i_fill_req) && wait_r >= (i_slow ? 2'h3 : 2'h2)) begin
            wait_r <= 2'h0;
            o_spill_ack <= i_spill_req;
            o_fill_ack <= i_fill_req & ~i_spill_req;
        end else begin
            wait_r <= (wait_r == 2'h3) ? wait_r : wait_r + 2'h1;
            o_spill_ack <= 1'b0;
            o_fill_ack <= 1'b0;
        end
    end
endmodule

// >>> tb.sv
`timescale 1ns/1ns
module tb;
    import rsf_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic op_valid = 1'b0;
    op_kind_e op_kind = OP_NONE;
    logic [6:0] a_ins = 7'h00;
    logic [6:0] a_locs = 7'h00;
    logic [6:0] a_outs = 7'h00;
    logic legacy = 1'b0;
    logic rd_en = 1'b0;
    logic [6:0] rd_addr = 7'h00;
    logic wr_en = 1'b0;
    logic [6:0] wr_addr = 7'h00;
    logic pfm_load = 1'b0;
    logic [6:0] pfm_sof = 7'h00;
    logic [6:0] pfm_sol = 7'h00;
    logic slow = 1'b0;
    logic op_ready, stall, rd_valid, rd_stacked, wr_en_o, wr_stacked, fault;
    logic spill_req, spill_ack, fill_req, fill_ack;
    logic [6:0] rd_phys, wr_phys, pfm_sof_o, pfm_sol_o;
    logic [7:0] dirty;
    int bad_count = 0;
    int n_tests = 0;

    always #50 clk = ~clk;

    register_stack_frame_renamer register_stack_frame_renamer_inst (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_op_valid(op_valid), .i_op_kind(op_kind),
        .i_alloc_ins(a_ins), .i_alloc_locs(a_locs), .i_alloc_outs(a_outs),
        .i_legacy_mode(legacy), .o_op_ready(op_ready), .o_stall(stall),
        .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_valid(rd_valid), .o_rd_phys(rd_phys),
        .o_rd_stacked(rd_stacked), .i_wr_en(wr_en), .i_wr_addr(wr_addr), .o_wr_en(wr_en_o),
        .o_wr_phys(wr_phys), .o_wr_stacked(wr_stacked), .o_illegal_op_fault(fault),
        .i_pfm_load(pfm_load), .i_pfm_sof(pfm_sof), .i_pfm_sol(pfm_sol),
        .o_pfm_sof(pfm_sof_o), .o_pfm_sol(pfm_sol_o), .o_spill_req(spill_req),
        .i_spill_ack(spill_ack), .o_fill_req(fill_req), .i_fill_ack(fill_ack),
        .o_dirty_count(dirty)
    );

    spill_engine_model spill_engine_model_inst (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_spill_req(spill_req), .i_fill_req(fill_req),
        .i_slow(slow), .o_spill_ack(spill_ack), .o_fill_ack(fill_ack)
    );

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // bounded, so a sequencer stuck in flush or fill shows up as a mismatch
    task automatic wait_ready();
        int n;
        n = 0;
        while (op_ready !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("op_ready", 8'(op_ready), 8'h01);
    endtask

    // each op is offered alone, first and unpredicated in its group
    task automatic op(input op_kind_e k, input logic [6:0] ni, input logic [6:0] nl,
                      input logic [6:0] no, output logic f);
        wait_ready();
        @(posedge clk);
        op_valid <= 1'b1;
        op_kind <= k;
        a_ins <= ni;
        a_locs <= nl;
        a_outs <= no;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        f = fault;
        @(posedge clk);
        #1;
        f = f | fault;
    endtask

    task automatic rd(input logic [6:0] a, input logic [6:0] p, input logic s);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk("rd_valid", 8'(rd_valid), 8'h01);
        chk("rd_phys", 8'(rd_phys), 8'(p));
        chk("rd_stacked", 8'(rd_stacked), 8'(s));
    endtask

    task automatic wr(input logic [6:0] a, input logic e, input logic [6:0] p);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
        chk("wr_en", 8'(wr_en_o), 8'(e));
        chk("fault", 8'(fault), 8'(!e));
        chk("wr_stacked", 8'(wr_stacked), 8'(a >= 7'h20));
        if (e) begin
            chk("wr_phys", 8'(wr_phys), 8'(p));
        end
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #1000000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        logic f;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("stall", 8'(stall), 8'h00);
        chk("dirty", dirty, 8'h00);
        $display("test reset done");
        // alloc and a write in the same group: the new size already applies
        @(posedge clk);
        op_valid <= 1'b1;
        op_kind <= OP_ALLOC;
        a_ins <= 7'h02;
        a_locs <= 7'h03;
        a_outs <= 7'h05;
        wr_en <= 1'b1;
        wr_addr <= 7'h29;
        @(posedge clk);
        op_valid <= 1'b0;
        wr_en <= 1'b0;
        #1;
        chk("wr_en", 8'(wr_en_o), 8'h01);
        wr(7'h2a, 1'b0, 7'h00);
        rd(7'h64, 7'h44, 1'b1);
        rd(7'h05, 7'h05, 1'b0);
        $display("test alloc done");
        op(OP_CALL, 7'h00, 7'h00, 7'h00, f);
        chk("pfm_sof", 8'(pfm_sof_o), 8'h0a);
        chk("pfm_sol", 8'(pfm_sol_o), 8'h05);
        chk("dirty", dirty, 8'h05);
        rd(7'h20, 7'h05, 1'b1);
        wr(7'h24, 1'b1, 7'h09);
        wr(7'h25, 1'b0, 7'h00);
        op(OP_ALLOC, 7'h05, 7'h00, 7'h03, f);
        rd(7'h20, 7'h05, 1'b1);
        wr(7'h27, 1'b1, 7'h0c);
        wr(7'h28, 1'b0, 7'h00);
        rd(7'h04, 7'h04, 1'b0);
        $display("test call done");
        op(OP_RET, 7'h00, 7'h00, 7'h00, f);
        rd(7'h20, 7'h00, 1'b1);
        wr(7'h29, 1'b1, 7'h09);
        wr(7'h2a, 1'b0, 7'h00);
        op(OP_ALLOC, 7'h32, 7'h28, 7'h0a, f);
        chk("alloc_fault", 8'(f), 8'h01);
        wr(7'h29, 1'b1, 7'h09);
        wr(7'h2a, 1'b0, 7'h00);
        op(OP_CLRRB, 7'h00, 7'h00, 7'h00, f);
        wr(7'h29, 1'b1, 7'h09);
        wr(7'h2a, 1'b0, 7'h00);
        $display("test return done");
        @(posedge clk);
        legacy <= 1'b1;
        rd(7'h28, 7'h08, 1'b1);
        wr(7'h78, 1'b1, 7'h58);
        op(OP_CALL, 7'h00, 7'h00, 7'h00, f);
        @(posedge clk);
        legacy <= 1'b0;
        wr(7'h29, 1'b1, 7'h09);
        wr(7'h2a, 1'b0, 7'h00);
        $display("test legacy done");
        op(OP_ALLOC, 7'h5a, 7'h00, 7'h06, f);
        wr(7'h7f, 1'b1, 7'h5f);
        op(OP_CALL, 7'h00, 7'h00, 7'h00, f);
        rd(7'h25, 7'h5f, 1'b1);
        op(OP_ALLOC, 7'h06, 7'h00, 7'h0a, f);
        chk("spill_req", 8'(spill_req), 8'h01);
        rd(7'h2a, 7'h04, 1'b1);
        @(posedge clk);
        slow <= 1'b1;
        op(OP_FLUSH, 7'h00, 7'h00, 7'h00, f);
        chk("stall", 8'(stall), 8'h01);
        wait_ready();
        chk("dirty", dirty, 8'h00);
        @(posedge clk);
        slow <= 1'b0;
        op(OP_RET, 7'h00, 7'h00, 7'h00, f);
        chk("fill_req", 8'(fill_req), 8'h01);
        wait_ready();
        rd(7'h20, 7'h00, 1'b1);
        wr(7'h7f, 1'b1, 7'h5f);
        $display("test flush done");
        // callers keep their own saved marker and put it back before returning
        @(posedge clk);
        pfm_load <= 1'b1;
        pfm_sof <= 7'h14;
        pfm_sol <= 7'h00;
        @(posedge clk);
        pfm_load <= 1'b0;
        #1;
        chk("pfm_sof", 8'(pfm_sof_o), 8'h14);
        op(OP_RET, 7'h00, 7'h00, 7'h00, f);
        wr(7'h33, 1'b1, 7'h13);
        wr(7'h34, 1'b0, 7'h00);
        $display("test reload done");
        tally_and_finish();
    end
endmodule
